// ==== core/gsf_ctrl.sv ====
// Behaviour
// - low byte selects target slave groups
// - group mask bit n selects group n
// - send to slaves in any selected group
// - 0x04 unfreeze, 0x08 freeze decoded
// - 0x10 unsync, 0x20 sync decoded
// - bit 15 is the send trigger
// - send once on each trigger edge
// - control word is one 16-bit word
// - station address defaults to zero
// - slow rate limits station to 59
// - nine bit rates, default 1.5M
// - highest polled station defaults to 126
// - token rotation time capped at maximum
// - bit-time tick from selected bit rate
//
// Purpose: group sync/freeze command issue and master network settings
// Assumes: inputs synchronous to clk_sys_i; slaves keep their own hold state
// Notes: the command byte may carry several codes; each set code is issued
`timescale 1ns/1ps
module gsf_ctrl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // control word write port
  input wire logic ctrl_we_i,
  input wire logic [15:0] ctrl_wdata_i,
  output logic [15:0] ctrl_rdata_o,
  // network settings
  input wire logic cfg_we_i,
  input wire logic [6:0] cfg_station_i,
  input wire logic [3:0] cfg_baud_i,
  input wire logic [6:0] cfg_hsa_i,
  input wire logic [24:0] cfg_ttr_i,
  output logic [6:0] station_o,
  output logic [3:0] baud_o,
  output logic [6:0] hsa_o,
  output logic [24:0] ttr_o,
  output logic bit_tick_o,
  // slave membership and command output
  input wire logic [7:0] slave_groups_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic [7:0] cmd_groups_o,
  output logic slave_hit_o
);
  import gsf_pkg::*;

  // ==========================================
  // control word register
  logic [15:0] ctrl_r;
  logic trig_prev_r;
  logic trig_edge;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (ctrl_we_i) begin
      ctrl_r <= ctrl_wdata_i;
    end
  end
  assign ctrl_rdata_o = ctrl_r;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= ctrl_r[TRIG_BIT];
    end
  end
  assign trig_edge = ctrl_r[TRIG_BIT] ^ trig_prev_r;

  // ==========================================
  // command issue
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_code_o <= 8'h00;
      cmd_groups_o <= 8'h00;
    end else begin
      cmd_valid_o <= trig_edge;
      if (trig_edge) begin
        // keep only the known codes, trigger stripped
        cmd_code_o <= ctrl_r[CMD_MSB:CMD_LSB] &
          (CMD_UNFREEZE | CMD_FREEZE | CMD_UNSYNC | CMD_SYNC);
        cmd_groups_o <= ctrl_r[GRP_MSB:GRP_LSB];
      end
    end
  end

  // any shared group addresses the slave
  assign slave_hit_o = cmd_valid_o && ((cmd_groups_o & slave_groups_i) != 8'h00);

  // ==========================================
  // network settings
  logic [6:0] station_r;
  logic [3:0] baud_r;
  logic [6:0] hsa_r;
  logic [24:0] ttr_r;
  logic [3:0] baud_nxt;
  logic [6:0] station_nxt;

  always_comb begin
    baud_nxt = (cfg_baud_i > BAUD_MAX) ? BAUD_MAX : cfg_baud_i;
    station_nxt = cfg_station_i;
    if (baud_nxt == 4'h0 && cfg_station_i > STATION_MAX_SLOW) begin
      station_nxt = STATION_MAX_SLOW;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      station_r <= STATION_RST;
      baud_r <= BAUD_RST;
      hsa_r <= HSA_RST;
      ttr_r <= TTR_RST;
    end else if (cfg_we_i) begin
      station_r <= station_nxt;
      baud_r <= baud_nxt;
      hsa_r <= cfg_hsa_i;
      ttr_r <= (cfg_ttr_i > TTR_MAX) ? TTR_MAX : cfg_ttr_i;
    end
  end
  assign station_o = station_r;
  assign baud_o = baud_r;
  assign hsa_o = hsa_r;
  assign ttr_o = ttr_r;

  // ==========================================
  // bit-time tick divider
  function automatic logic [15:0] bit_div(input logic [3:0] idx);
    case (idx)
      4'h0: bit_div = BIT_DIV_9K6;
      4'h1: bit_div = BIT_DIV_19K2;
      4'h2: bit_div = BIT_DIV_93K75;
      4'h3: bit_div = BIT_DIV_187K5;
      4'h4: bit_div = BIT_DIV_500K;
      4'h5: bit_div = BIT_DIV_1M5;
      4'h6: bit_div = BIT_DIV_3M;
      4'h7: bit_div = BIT_DIV_6M;
      default: bit_div = BIT_DIV_12M;
    endcase
  endfunction : bit_div

  logic [15:0] div_cnt_r;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_cnt_r <= BIT_DIV_RST;
      bit_tick_o <= 1'b0;
    end else if (div_cnt_r >= bit_div(baud_r) - 16'h0001) begin
      div_cnt_r <= BIT_DIV_RST;
      bit_tick_o <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
      bit_tick_o <= 1'b0;
    end
  end

  // ==========================================
  // checks
  property p_edge_issue;
    @(posedge clk_sys_i) disable iff (srst_i)
    trig_edge |=> cmd_valid_o;
  endproperty
  a_edge_issue: assert property (p_edge_issue) else $error("trigger edge not issued");

  property p_no_edge_quiet;
    @(posedge clk_sys_i) disable iff (srst_i)
    !trig_edge |=> !cmd_valid_o;
  endproperty
  a_no_edge_quiet: assert property (p_no_edge_quiet) else $error("spurious command");

  property p_groups;
    @(posedge clk_sys_i) disable iff (srst_i)
    trig_edge |=> cmd_groups_o == $past(ctrl_r[7:0]);
  endproperty
  a_groups: assert property (p_groups) else $error("group mask wrong");

  property p_code;
    @(posedge clk_sys_i) disable iff (srst_i)
    trig_edge |=> cmd_code_o == ($past(ctrl_r[15:8]) & 8'h3c);
  endproperty
  a_code: assert property (p_code) else $error("command code wrong");

  property p_no_trig_in_code;
    @(posedge clk_sys_i) disable iff (srst_i)
    cmd_valid_o |-> !cmd_code_o[7];
  endproperty
  a_no_trig_in_code: assert property (p_no_trig_in_code) else $error("trigger leaked");

  property p_hit;
    @(posedge clk_sys_i) disable iff (srst_i)
    slave_hit_o |-> (cmd_groups_o & slave_groups_i) != 8'h00;
  endproperty
  a_hit: assert property (p_hit) else $error("slave hit without group");

  property p_one_shot;
    @(posedge clk_sys_i) disable iff (srst_i)
    cmd_valid_o && !$past(ctrl_we_i) |=> !cmd_valid_o;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("command repeated");

  property p_slow_station;
    @(posedge clk_sys_i) disable iff (srst_i)
    baud_r == 4'h0 |-> station_r <= 7'h3b;
  endproperty
  a_slow_station: assert property (p_slow_station) else $error("station too high");

  property p_ttr;
    @(posedge clk_sys_i) disable iff (srst_i)
    ttr_r <= 25'd20971200;
  endproperty
  a_ttr: assert property (p_ttr) else $error("rotation time over max");

  property p_baud;
    @(posedge clk_sys_i) disable iff (srst_i)
    baud_r <= 4'h8;
  endproperty
  a_baud: assert property (p_baud) else $error("baud index out of range");

  property p_reset_vals;
    @(posedge clk_sys_i)
    srst_i |=> station_r == 7'h00 && hsa_r == 7'h7e && baud_r == 4'h5;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_reset_cmd;
    @(posedge clk_sys_i)
    srst_i |=> !cmd_valid_o && cmd_code_o == 8'h00 && cmd_groups_o == 8'h00 && !trig_edge;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("command state after reset");

  property p_known_codes;
    @(posedge clk_sys_i) disable iff (srst_i)
    cmd_valid_o |-> (cmd_code_o & 8'hc3) == 8'h00;
  endproperty
  a_known_codes: assert property (p_known_codes) else $error("unknown code issued");

  property p_hit_shared;
    @(posedge clk_sys_i) disable iff (srst_i)
    cmd_valid_o && ((cmd_groups_o & slave_groups_i) != 8'h00) |-> slave_hit_o;
  endproperty
  a_hit_shared: assert property (p_hit_shared) else $error("member slave missed");

  property p_hit_idle;
    @(posedge clk_sys_i) disable iff (srst_i)
    !cmd_valid_o |-> !slave_hit_o;
  endproperty
  a_hit_idle: assert property (p_hit_idle) else $error("slave hit without command");

  property p_cmd_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
    !$past(srst_i) && !cmd_valid_o |-> $stable(cmd_code_o) && $stable(cmd_groups_o);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command fields moved");

  property p_write_lands;
    @(posedge clk_sys_i) disable iff (srst_i)
    ctrl_we_i |=> ctrl_r == $past(ctrl_wdata_i);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("control write lost");

  property p_settings_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
    !$past(srst_i) && !$past(cfg_we_i) |->
      $stable(station_r) && $stable(baud_r) && $stable(hsa_r) && $stable(ttr_r);
  endproperty
  a_settings_hold: assert property (p_settings_hold) else $error("settings moved");

  property p_station_load;
    @(posedge clk_sys_i) disable iff (srst_i)
    cfg_we_i && cfg_baud_i != 4'h0 |=> station_r == $past(cfg_station_i);
  endproperty
  a_station_load: assert property (p_station_load) else $error("station not loaded");

  property p_hsa_load;
    @(posedge clk_sys_i) disable iff (srst_i)
    cfg_we_i |=> hsa_r == $past(cfg_hsa_i);
  endproperty
  a_hsa_load: assert property (p_hsa_load) else $error("highest station not loaded");

  property p_ttr_load;
    @(posedge clk_sys_i) disable iff (srst_i)
    cfg_we_i && cfg_ttr_i <= TTR_MAX |=> ttr_r == $past(cfg_ttr_i);
  endproperty
  a_ttr_load: assert property (p_ttr_load) else $error("rotation time not loaded");

  property p_baud_load;
    @(posedge clk_sys_i) disable iff (srst_i)
    cfg_we_i && cfg_baud_i <= BAUD_MAX |=> baud_r == $past(cfg_baud_i);
  endproperty
  a_baud_load: assert property (p_baud_load) else $error("baud index not loaded");

  property p_tick_pulse;
    @(posedge clk_sys_i) disable iff (srst_i)
    bit_tick_o |=> !bit_tick_o;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("bit tick too long");

  property p_tick_cnt;
    @(posedge clk_sys_i) disable iff (srst_i)
    bit_tick_o |-> div_cnt_r == BIT_DIV_RST;
  endproperty
  a_tick_cnt: assert property (p_tick_cnt) else $error("tick without counter wrap");

  c_rise: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    trig_edge && ctrl_r[15]);
  c_fall: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    trig_edge && !ctrl_r[15]);
  c_sync_hit: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    slave_hit_o && cmd_code_o[5]);
  c_freeze: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    cmd_valid_o && cmd_code_o[3]);
  c_unsync_hit: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    slave_hit_o && cmd_code_o[4]);
endmodule : gsf_ctrl

// ==== core/gsf_pkg.sv ====
// Purpose: constants for the group sync/freeze command block
// Assumes: one 200 MHz clock, synchronous reset
// Notes: command codes and network defaults live here
package gsf_pkg;
  // ==========================================
  // control word layout
  localparam int GRP_LSB = 0;
  localparam int GRP_MSB = 7;
  localparam int CMD_LSB = 8;
  localparam int CMD_MSB = 15;
  localparam int TRIG_BIT = 15;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // ==========================================
  // command codes in the command byte
  localparam logic [7:0] CMD_UNFREEZE = 8'h04;
  localparam logic [7:0] CMD_FREEZE = 8'h08;
  localparam logic [7:0] CMD_UNSYNC = 8'h10;
  localparam logic [7:0] CMD_SYNC = 8'h20;
  localparam logic [7:0] CMD_TRIG = 8'h80;
  // ==========================================
  // network settings
  localparam logic [6:0] STATION_RST = 7'h00;
  localparam logic [6:0] STATION_MAX_SLOW = 7'h3b;
  localparam logic [6:0] HSA_RST = 7'h7e;
  localparam logic [3:0] BAUD_RST = 4'h5;
  localparam logic [3:0] BAUD_MAX = 4'h8;
  localparam logic [24:0] TTR_MAX = 25'd20971200;
  localparam logic [24:0] TTR_RST = 25'd1872;
  localparam int CLK_HZ = 200000000;
  // bit-time dividers per baud index, in clock cycles
  localparam logic [15:0] BIT_DIV_RST = 16'h0000;
  localparam logic [15:0] BIT_DIV_9K6 = 16'(CLK_HZ / 9600);
  localparam logic [15:0] BIT_DIV_19K2 = 16'(CLK_HZ / 19200);
  localparam logic [15:0] BIT_DIV_93K75 = 16'(CLK_HZ / 93750);
  localparam logic [15:0] BIT_DIV_187K5 = 16'(CLK_HZ / 187500);
  localparam logic [15:0] BIT_DIV_500K = 16'(CLK_HZ / 500000);
  localparam logic [15:0] BIT_DIV_1M5 = 16'(CLK_HZ / 1500000);
  localparam logic [15:0] BIT_DIV_3M = 16'(CLK_HZ / 3000000);
  localparam logic [15:0] BIT_DIV_6M = 16'(CLK_HZ / 6000000);
  localparam logic [15:0] BIT_DIV_12M = 16'(CLK_HZ / 12000000);
  typedef enum logic [2:0] {
    GSF_OP_NONE,
    GSF_OP_UNFREEZE,
    GSF_OP_FREEZE,
    GSF_OP_UNSYNC,
    GSF_OP_SYNC
  } gsf_op_t;
endpackage : gsf_pkg

// ==== testbench/gsf_slave_model.sv ====
// Purpose: remote slave model keeping its sync and freeze hold state
// Assumes: commands arrive as one-cycle pulses with slave_hit_i
// Notes: group membership is chosen by the bench
`timescale 1ns/1ps
module gsf_slave_model
  import gsf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // command side
  input wire logic [7:0] member_i,
  input wire logic slave_hit_i,
  input wire logic [7:0] cmd_code_i,
  output logic [7:0] slave_groups_o,
  output logic outs_held_o,
  output logic ins_frozen_o
);
  assign slave_groups_o = member_i;
  // ==========================================
  // hold flags
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      outs_held_o <= 1'b0;
      ins_frozen_o <= 1'b0;
    end else if (slave_hit_i) begin
      if (|(cmd_code_i & (CMD_SYNC | CMD_UNSYNC))) outs_held_o <= cmd_code_i[5];
      if (|(cmd_code_i & (CMD_FREEZE | CMD_UNFREEZE))) ins_frozen_o <= cmd_code_i[3];
    end
  end
endmodule : gsf_slave_model

// ==== testbench/fieldbus_group_sync_freeze_control_tb.sv ====
// Purpose: self-checking bench for gsf_ctrl
// Assumes: inputs change on the falling edge
// Notes: expected commands wait in a queue for the monitor
`timescale 1ns/1ps
module fieldbus_group_sync_freeze_control_tb;
  import gsf_pkg::*;
  logic clk_sys_i, srst_i, ctrl_we_i, cfg_we_i, bit_tick_o, cmd_valid_o, slave_hit_o;
  logic [15:0] ctrl_wdata_i, ctrl_rdata_o, shadow, ex;
  logic [6:0] cfg_station_i, cfg_hsa_i, station_o, hsa_o;
  logic [3:0] cfg_baud_i, baud_o;
  logic [24:0] cfg_ttr_i, ttr_o;
  logic [7:0] slave_groups_i, cmd_code_o, cmd_groups_o, member, code, grp;
  logic held, frozen;
  logic [15:0] expq[$];
  int n_errors = 0;
  int compares = 0;
  int n;
  gsf_ctrl gsf_ctrl_inst (.clk_sys_i, .srst_i, .ctrl_we_i, .ctrl_wdata_i, .ctrl_rdata_o,
    .cfg_we_i, .cfg_station_i, .cfg_baud_i, .cfg_hsa_i, .cfg_ttr_i, .station_o, .baud_o,
    .hsa_o, .ttr_o, .bit_tick_o, .slave_groups_i, .cmd_valid_o, .cmd_code_o, .cmd_groups_o,
    .slave_hit_o);
  gsf_slave_model gsf_slave_model_inst (.clk_sys_i, .srst_i, .member_i(member),
    .slave_hit_i(slave_hit_o), .cmd_code_i(cmd_code_o), .slave_groups_o(slave_groups_i),
    .outs_held_o(held), .ins_frozen_o(frozen));
  // ==========================================
  // helpers
  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic wr(logic [15:0] w);
    if (w[TRIG_BIT] !== shadow[TRIG_BIT]) expq.push_back({w[15:8] & 8'h3c, w[7:0]});
    shadow = w;
    ctrl_we_i = 1'b1;
    ctrl_wdata_i = w;
    @(negedge clk_sys_i);
  endtask : wr
  task automatic cfg(logic [6:0] st, logic [3:0] bd, logic [6:0] hs, logic [24:0] tt);
    cfg_we_i = 1'b1;
    {cfg_station_i, cfg_baud_i, cfg_hsa_i, cfg_ttr_i} = {st, bd, hs, tt};
    @(negedge clk_sys_i);
    cfg_we_i = 1'b0;
    @(negedge clk_sys_i);
  endtask : cfg
  // ==========================================
  // clock, watchdog and monitor
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #50us;
    n_errors++;
    summarize();
  end
  always @(negedge clk_sys_i) begin
    if (!srst_i && cmd_valid_o === 1'b1) begin
      if (expq.size() == 0) begin
        n_errors++;
        $display("unexpected cmd_valid_o: expected 0 seen 1");
      end else begin
        ex = expq.pop_front();
        check("cmd_code_o", ex[15:8], cmd_code_o);
        check("cmd_groups_o", ex[7:0], cmd_groups_o);
        check("slave_hit_o", 32'(|(ex[7:0] & member)), slave_hit_o);
      end
    end
  end
  // ==========================================
  // tests
  initial begin
    {srst_i, ctrl_we_i, cfg_we_i, ctrl_wdata_i, shadow, member} = '0;
    {cfg_station_i, cfg_baud_i, cfg_hsa_i, cfg_ttr_i} = '0;
    srst_i = 1'b1;
    void'($urandom(32'hb8396245));
    repeat (8) @(negedge clk_sys_i);
    srst_i = 1'b0;
    check("settings", {7'd0, 4'd5, 7'd126, 25'd1872}, {station_o, baud_o, hsa_o, ttr_o});
    for (int i = 0; i < 48; i++) begin
      member = 8'($urandom);
      code = (8'h04 << (i % 4)) | (8'($urandom) & 8'h43);
      grp = i[0] ? 8'($urandom) : 8'h01 << i[3:1];
      wr({shadow[15] ^ (i % 5 != 0), code[6:0], grp});
      ctrl_we_i = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      check("ctrl_rdata_o", shadow, ctrl_rdata_o);
    end
    member = 8'h10;
    wr({~shadow[15], 7'h04, 8'hff});
    wr({~shadow[15], 7'h20, 8'h10});
    wr({~shadow[15], 7'h08, 8'h01});
    ctrl_we_i = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    check("slave hold", 2'b10, {held, frozen});
    cfg(7'd100, 4'd0, 7'd126, 25'd20971201);
    check("slow settings", {7'd59, 4'd0, 25'd20971200}, {station_o, baud_o, ttr_o});
    cfg(7'd100, 4'd15, 7'd50, 25'd0);
    check("fast settings", {7'd100, 4'd8, 7'd50, 25'd0}, {station_o, baud_o, hsa_o, ttr_o});
    while (bit_tick_o !== 1'b1) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    n = 1;
    while (bit_tick_o !== 1'b1 && n < 1000) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("bit time", 200000000 / 12000000, n);
    check("pending commands", 0, expq.size());
    summarize();
  end
endmodule : fieldbus_group_sync_freeze_control_tb
